//--- dprb_consts.svh
// Constants of the dual-port RAM block: geometry, register map, field layout and reset values
`ifndef DPRB_CONSTS_SVH
`define DPRB_CONSTS_SVH
`define DPRB_LANE_BITS 9
`define DPRB_LANE_TOTAL 2048
`define DPRB_LANES_PER_WORD 4
`define DPRB_LOC_BITS 11
`define DPRB_MAX_WIDTH 36
`define DPRB_PORT_WIDTH 18
`define DPRB_WIDTH_BITS 6
`define DPRB_CNT_BITS 16
`define DPRB_ONE_BLOCK_TOP 11'h3ff
`define DPRB_TWO_BLOCK_TOP 11'h7ff
`define DPRB_MASK_ONE_LANE 36'h0000001ff
`define DPRB_MASK_TWO_LANES 36'h00003ffff
`define DPRB_APB_ADDR_BITS 12
`define DPRB_OFF_CTRL 12'h000
`define DPRB_OFF_WIDTH 12'h004
`define DPRB_OFF_COUNT 12'h008
`define DPRB_CTRL_BITS 9
`define DPRB_CTRL_MODE 1:0
`define DPRB_CTRL_PIPE 2
`define DPRB_CTRL_INV_A 3
`define DPRB_CTRL_INV_B 4
`define DPRB_CTRL_DEPTH_A 6:5
`define DPRB_CTRL_DEPTH_B 8:7
`define DPRB_CTRL_RESET 9'h000
`define DPRB_WIDTH_REG_BITS 14
`define DPRB_WIDTH_A 5:0
`define DPRB_WIDTH_B 13:8
`define DPRB_WIDTH_RESET 14'h1212
`endif

//--- dprb_pkg.sv
// Types shared by the dual-port RAM block
package dprb_pkg;
    typedef enum logic [1:0] {
        DPRB_MODE_SINGLE = 2'h0,
        DPRB_MODE_CASCADE = 2'h1,
        DPRB_MODE_TRUE_DUAL = 2'h2
    } dprb_mode_t;
    typedef enum logic [1:0] {
        DPRB_DEPTH_512 = 2'h0,
        DPRB_DEPTH_1024 = 2'h1,
        DPRB_DEPTH_2048 = 2'h2
    } dprb_depth_t;
endpackage : dprb_pkg

//--- dprb_port_if.sv
// Synchronised port request passed from a pin synchroniser to the RAM core
`timescale 1ns/1ps
`include "dprb_consts.svh"
interface dprb_port_if;
    logic stb;
    logic [`DPRB_LOC_BITS-1:0] loc;
    logic [`DPRB_MAX_WIDTH-1:0] word;
    logic [`DPRB_LANES_PER_WORD-1:0] laneEn;
    logic wrSel;
    logic rdSel;
    modport src (output stb, loc, word, laneEn, wrSel, rdSel);
    modport dst (input stb, loc, word, laneEn, wrSel, rdSel);
endinterface : dprb_port_if

//--- dprb_pin_sync.sv
// Two-stage synchroniser and port clock edge detector for one RAM port
`timescale 1ns/1ps
`include "dprb_consts.svh"
module dprb_pin_sync
    import dprb_pkg::*;
(
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // Raw port pins
    input wire logic pinClock,
    input wire logic invertClock,
    input wire logic [`DPRB_LOC_BITS-1:0] pinLoc,
    input wire logic [`DPRB_MAX_WIDTH-1:0] pinWord,
    input wire logic [`DPRB_LANES_PER_WORD-1:0] pinLaneEn,
    input wire logic pinWrSel,
    input wire logic pinRdSel,
    // Synchronised request
    dprb_port_if.src req
);
    localparam int W = `DPRB_LOC_BITS + `DPRB_MAX_WIDTH + `DPRB_LANES_PER_WORD + 3;

    logic [W-1:0] stage1_reg;
    logic [W-1:0] stage1_next;
    logic [W-1:0] stage2_reg;
    logic [W-1:0] stage2_next;
    logic lastLevel_reg;
    logic lastLevel_next;
    logic level;

    // Clock and data share the same two stages so they stay aligned
    always_comb begin
        stage1_next = rst_n ? {pinClock, pinLoc, pinWord, pinLaneEn, pinWrSel, pinRdSel} : '0;
        stage2_next = rst_n ? stage1_reg : '0;
        level = stage2_reg[W-1] ^ invertClock; // R3
        // Reset to high, but the stages reset to zero, so with a direct clock a pin already high still gives one false edge
        lastLevel_next = rst_n ? level : 1'b1;
    end

    // Synchroniser flops
    always_ff @(posedge mclk) begin
        stage1_reg <= stage1_next;
        stage2_reg <= stage2_next;
        lastLevel_reg <= lastLevel_next;
    end

    // One-cycle strobe on the active edge of the port clock
    assign req.stb = level & ~lastLevel_reg; // R3
    assign req.loc = stage2_reg[W-2 -: `DPRB_LOC_BITS];
    assign req.word = stage2_reg[W-2-`DPRB_LOC_BITS -: `DPRB_MAX_WIDTH];
    assign req.laneEn = stage2_reg[2 +: `DPRB_LANES_PER_WORD];
    assign req.wrSel = stage2_reg[1];
    assign req.rdSel = stage2_reg[0];

    chk_edge_spacing: assert property ( // R3
        @(posedge mclk) disable iff (!rst_n) req.stb |=> !req.stb)
        else $error("port strobe on two cycles in a row");
endmodule : dprb_pin_sync

//--- dprb_lane_map.sv
// Maps a port location onto the lane array for the configured shape
`timescale 1ns/1ps
`include "dprb_consts.svh"
module dprb_lane_map
    import dprb_pkg::*;
(
    // Shape selection
    input wire dprb_mode_t mode,
    input wire dprb_depth_t depth,
    input wire logic [`DPRB_WIDTH_BITS-1:0] width,
    input wire logic [`DPRB_LOC_BITS-1:0] loc,
    // Mapped location
    output logic [`DPRB_LOC_BITS-1:0] baseLane,
    output logic [`DPRB_LANES_PER_WORD-1:0] laneMask,
    output logic [`DPRB_MAX_WIDTH-1:0] bitMask
);
    logic [1:0] laneLog;
    logic [`DPRB_LOC_BITS-1:0] wordTop;
    logic [`DPRB_MAX_WIDTH-1:0] widthMask;
    logic [`DPRB_MAX_WIDTH-1:0] coverMask;

    // Wider words take more lanes and fewer location bits
    always_comb begin
        case (mode)
            DPRB_MODE_CASCADE: begin // R8 R9
                case (depth)
                    DPRB_DEPTH_512: laneLog = 2'h2;
                    DPRB_DEPTH_2048: laneLog = 2'h0;
                    default: laneLog = 2'h1;
                endcase
            end
            DPRB_MODE_TRUE_DUAL: laneLog = (depth == DPRB_DEPTH_2048) ? 2'h0 : 2'h1;
            default: laneLog = 2'h1;
        endcase
        wordTop = (mode == DPRB_MODE_SINGLE || mode > DPRB_MODE_TRUE_DUAL) ?
            (`DPRB_ONE_BLOCK_TOP >> laneLog) : (`DPRB_TWO_BLOCK_TOP >> laneLog); // R7
        baseLane = (loc & wordTop) << laneLog; // R7
        case (laneLog)
            2'h0: begin
                laneMask = 4'h1;
                coverMask = `DPRB_MASK_ONE_LANE;
            end
            2'h1: begin
                laneMask = 4'h3;
                coverMask = `DPRB_MASK_TWO_LANES;
            end
            default: begin
                laneMask = 4'hf;
                coverMask = '1;
            end
        endcase
        // Widths past the word are clipped to the word
        if (width >= `DPRB_WIDTH_BITS'(`DPRB_MAX_WIDTH)) begin
            widthMask = '1;
        end else begin
            widthMask = (`DPRB_MAX_WIDTH'(1) << width) - `DPRB_MAX_WIDTH'(1);
        end
        bitMask = widthMask & coverMask; // R2
    end
endmodule : dprb_lane_map

//--- dprb_ram_top.sv
// Top of the dual-port RAM block: two-block storage, port engines and APB registers
//
// Design decisions made here: register access over APB and the placing of the registers.
`timescale 1ns/1ps
`include "dprb_consts.svh"
// Overview of operation
// R1: Each block stores 9,216 bits as 512 words of 18 bits, separate ports.
// R2: Read width and write width are configured independently.
// R3: Each port has its own clock, used direct or inverted.
// R4: Write port takes 18-bit word, 9-bit location, two 9-bit lane enables.
// R5: Read port takes location and select, returns 18-bit word on read clock.
// R6: Read data is direct or pipelined; pipelining adds one read clock latency.
// R7: Location bits map to storage by configured depth and width.
// R8: Two blocks join to 1024x18 or 512x36 without fabric logic.
// R9: Shapes: 512 by up to 18 on one block; 512x36, 1024x18, 2048x9 on two.
// R10: Larger memories are built by the user from several blocks in fabric.
// R11: True dual-port mode lets each port read and write on its own clock.
// R12: User must not read and write one location at once; no collision guard.
// R13: User must not write one location from both ports; shared reads are fine.
// R14: Each true dual-port port has word, location, strobe, select, clock, read word.
// R15: Writes need select and lane enable; read output changes only on selected reads. Pipelined, the code updates it on every read clock edge.
module dprb_ram_top
    import dprb_pkg::*;
(
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // APB register slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [`DPRB_APB_ADDR_BITS-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Simple dual-port write side
    input wire logic writeClock,
    input wire logic [`DPRB_LOC_BITS-1:0] writeLocation,
    input wire logic [`DPRB_MAX_WIDTH-1:0] writeWordIn,
    input wire logic [`DPRB_LANES_PER_WORD-1:0] writeLaneEn,
    input wire logic writePortSelect,
    // Simple dual-port read side
    input wire logic readClock,
    input wire logic [`DPRB_LOC_BITS-1:0] readLocation,
    input wire logic readPortSelect,
    output logic [`DPRB_MAX_WIDTH-1:0] readWordOut,
    // True dual-port first port
    input wire logic firstPortClock,
    input wire logic [`DPRB_LOC_BITS-1:0] firstPortLocation,
    input wire logic [`DPRB_PORT_WIDTH-1:0] firstPortWriteWord,
    input wire logic firstPortWriteStrobe,
    input wire logic firstPortSelect,
    output logic [`DPRB_PORT_WIDTH-1:0] firstPortReadWord,
    // True dual-port second port
    input wire logic secondPortClock,
    input wire logic [`DPRB_LOC_BITS-1:0] secondPortLocation,
    input wire logic [`DPRB_PORT_WIDTH-1:0] secondPortWriteWord,
    input wire logic secondPortWriteStrobe,
    input wire logic secondPortSelect,
    output logic [`DPRB_PORT_WIDTH-1:0] secondPortReadWord
);
    localparam int PAD = `DPRB_MAX_WIDTH - `DPRB_PORT_WIDTH;
    localparam int LB = `DPRB_LANE_BITS;

    // Lane array covering both blocks; contents have no reset
    logic [LB-1:0] mem [0:`DPRB_LANE_TOTAL-1]; // R1

    logic [`DPRB_CTRL_BITS-1:0] ctrl_reg;
    logic [`DPRB_CTRL_BITS-1:0] ctrl_next;
    logic [`DPRB_WIDTH_REG_BITS-1:0] width_reg;
    logic [`DPRB_WIDTH_REG_BITS-1:0] width_next;
    logic [`DPRB_CNT_BITS-1:0] wrCount_reg;
    logic [`DPRB_CNT_BITS-1:0] wrCount_next;
    logic [`DPRB_CNT_BITS-1:0] rdCount_reg;
    logic [`DPRB_CNT_BITS-1:0] rdCount_next;
    logic [31:0] prdata_reg;
    logic [31:0] prdata_next;
    logic pready_reg;
    logic pready_next;
    logic pslverr_reg;
    logic pslverr_next;
    logic [`DPRB_MAX_WIDTH-1:0] outA_reg;
    logic [`DPRB_MAX_WIDTH-1:0] outA_next;
    logic [`DPRB_MAX_WIDTH-1:0] outB_reg;
    logic [`DPRB_MAX_WIDTH-1:0] outB_next;
    logic [`DPRB_MAX_WIDTH-1:0] pipeA_reg;
    logic [`DPRB_MAX_WIDTH-1:0] pipeA_next;
    logic [`DPRB_MAX_WIDTH-1:0] pipeB_reg;
    logic [`DPRB_MAX_WIDTH-1:0] pipeB_next;

    dprb_mode_t mode;
    logic trueDual;
    logic pipeOn;
    logic aClk;
    logic [`DPRB_LOC_BITS-1:0] aLoc;
    logic [`DPRB_MAX_WIDTH-1:0] aWord;
    logic [`DPRB_LANES_PER_WORD-1:0] aLane;
    logic aWr;
    logic aRd;
    logic bClk;
    logic [`DPRB_LOC_BITS-1:0] bLoc;
    logic [`DPRB_MAX_WIDTH-1:0] bWord;
    logic [`DPRB_LANES_PER_WORD-1:0] bLane;
    logic bWr;
    logic bRd;
    logic [`DPRB_LOC_BITS-1:0] baseA;
    logic [`DPRB_LOC_BITS-1:0] baseB;
    logic [`DPRB_LANES_PER_WORD-1:0] laneMaskA;
    logic [`DPRB_LANES_PER_WORD-1:0] laneMaskB;
    logic [`DPRB_MAX_WIDTH-1:0] bitMaskA;
    logic [`DPRB_MAX_WIDTH-1:0] bitMaskB;
    logic [`DPRB_LANES_PER_WORD-1:0] wrLaneA;
    logic [`DPRB_LANES_PER_WORD-1:0] wrLaneB;
    logic [`DPRB_MAX_WIDTH-1:0] wordA;
    logic [`DPRB_MAX_WIDTH-1:0] wordB;
    logic [`DPRB_MAX_WIDTH-1:0] rdA;
    logic [`DPRB_MAX_WIDTH-1:0] rdB;
    logic rdEvA;
    logic rdEvB;
    logic apbSetup;
    logic apbWrite;
    logic unmapped;

    dprb_port_if portA ();
    dprb_port_if portB ();

    assign mode = dprb_mode_t'(ctrl_reg[`DPRB_CTRL_MODE]);
    assign trueDual = (mode == DPRB_MODE_TRUE_DUAL);
    assign pipeOn = ctrl_reg[`DPRB_CTRL_PIPE];

    // Route pins to the two engines; engine A writes, engine B reads unless true dual
    always_comb begin
        if (trueDual) begin
            aClk = firstPortClock;
            aLoc = firstPortLocation;
            aWord = {{PAD{1'b0}}, firstPortWriteWord};
            aLane = {`DPRB_LANES_PER_WORD{firstPortWriteStrobe}};
            aWr = firstPortSelect & firstPortWriteStrobe; // R11
            aRd = firstPortSelect & ~firstPortWriteStrobe; // R11
            bClk = secondPortClock;
            bLoc = secondPortLocation;
            bWord = {{PAD{1'b0}}, secondPortWriteWord};
            bLane = {`DPRB_LANES_PER_WORD{secondPortWriteStrobe}};
            bWr = secondPortSelect & secondPortWriteStrobe; // R11
            bRd = secondPortSelect & ~secondPortWriteStrobe; // R11
        end else begin
            aClk = writeClock;
            aLoc = writeLocation;
            aWord = writeWordIn;
            aLane = writeLaneEn; // R4
            aWr = writePortSelect;
            aRd = 1'b0;
            bClk = readClock;
            bLoc = readLocation;
            bWord = '0;
            bLane = '0;
            bWr = 1'b0;
            bRd = readPortSelect; // R5
        end
    end

    // Engine A synchroniser on its own port clock
    dprb_pin_sync syncA (
        .mclk(mclk),
        .rst_n(rst_n),
        .pinClock(aClk),
        .invertClock(ctrl_reg[`DPRB_CTRL_INV_A]),
        .pinLoc(aLoc),
        .pinWord(aWord),
        .pinLaneEn(aLane),
        .pinWrSel(aWr),
        .pinRdSel(aRd),
        .req(portA.src)
    );

    // Engine B synchroniser on its own port clock
    dprb_pin_sync syncB (
        .mclk(mclk),
        .rst_n(rst_n),
        .pinClock(bClk),
        .invertClock(ctrl_reg[`DPRB_CTRL_INV_B]),
        .pinLoc(bLoc),
        .pinWord(bWord),
        .pinLaneEn(bLane),
        .pinWrSel(bWr),
        .pinRdSel(bRd),
        .req(portB.src)
    );

    // Shape of each side is set on its own, so read and write widths may differ
    dprb_lane_map mapA (
        .mode(mode),
        .depth(dprb_depth_t'(ctrl_reg[`DPRB_CTRL_DEPTH_A])),
        .width(width_reg[`DPRB_WIDTH_A]),
        .loc(portA.loc),
        .baseLane(baseA),
        .laneMask(laneMaskA),
        .bitMask(bitMaskA)
    );

    dprb_lane_map mapB (
        .mode(mode),
        .depth(dprb_depth_t'(ctrl_reg[`DPRB_CTRL_DEPTH_B])),
        .width(width_reg[`DPRB_WIDTH_B]),
        .loc(portB.loc),
        .baseLane(baseB),
        .laneMask(laneMaskB),
        .bitMask(bitMaskB)
    );

    // Collect the lanes of one word; lanes outside the mask read as zero
    function automatic logic [`DPRB_MAX_WIDTH-1:0] gatherLanes(
        input logic [`DPRB_LOC_BITS-1:0] base,
        input logic [`DPRB_LANES_PER_WORD-1:0] lanes);
        logic [`DPRB_MAX_WIDTH-1:0] word;
        word = '0;
        for (int k = 0; k < `DPRB_LANES_PER_WORD; k++) begin
            if (lanes[k]) begin
                word[k*LB +: LB] = mem[base + `DPRB_LOC_BITS'(k)];
            end
        end
        return word;
    endfunction : gatherLanes

    // Write lanes and read data of both engines
    always_comb begin
        wrLaneA = {`DPRB_LANES_PER_WORD{portA.stb & portA.wrSel}} & portA.laneEn & laneMaskA; // R15
        wrLaneB = {`DPRB_LANES_PER_WORD{portB.stb & portB.wrSel}} & portB.laneEn & laneMaskB; // R15
        wordA = portA.word & bitMaskA;
        wordB = portB.word & bitMaskB;
        rdA = gatherLanes(baseA, laneMaskA) & bitMaskA; // R7
        rdB = gatherLanes(baseB, laneMaskB) & bitMaskB; // R7
        rdEvA = portA.stb & portA.rdSel;
        rdEvB = portB.stb & portB.rdSel;
    end

    // Storage write; no collision guard, on a shared lane the higher lane index k wins, engine B on equal k
    always_ff @(posedge mclk) begin
        for (int k = 0; k < `DPRB_LANES_PER_WORD; k++) begin
            if (wrLaneA[k]) begin
                mem[baseA + `DPRB_LOC_BITS'(k)] <= wordA[k*LB +: LB]; // R4
            end
            if (wrLaneB[k]) begin
                mem[baseB + `DPRB_LOC_BITS'(k)] <= wordB[k*LB +: LB]; // R11
            end
        end
    end

    // Read outputs: direct, or through one more stage moved on each port clock edge
    always_comb begin
        outA_next = outA_reg;
        outB_next = outB_reg;
        pipeA_next = pipeA_reg;
        pipeB_next = pipeB_reg;
        if (pipeOn) begin
            if (portA.stb) outA_next = pipeA_reg; // R6
            if (portB.stb) outB_next = pipeB_reg; // R6
            if (rdEvA) pipeA_next = rdA;
            if (rdEvB) pipeB_next = rdB;
        end else begin
            if (rdEvA) outA_next = rdA; // R15
            if (rdEvB) outB_next = rdB; // R5
        end
        if (!rst_n) begin
            outA_next = '0;
            outB_next = '0;
            pipeA_next = '0;
            pipeB_next = '0;
        end
    end

    // Activity counters show the block's own state to software
    always_comb begin
        wrCount_next = wrCount_reg + `DPRB_CNT_BITS'(|wrLaneA) + `DPRB_CNT_BITS'(|wrLaneB);
        rdCount_next = rdCount_reg + `DPRB_CNT_BITS'(rdEvA) + `DPRB_CNT_BITS'(rdEvB);
        if (!rst_n) begin
            wrCount_next = '0;
            rdCount_next = '0;
        end
    end

    // APB slave: data and error are prepared in setup so the answer has no wait state
    always_comb begin
        apbSetup = psel & ~penable;
        apbWrite = psel & penable & pready_reg & pwrite;
        unmapped = !(paddr == `DPRB_OFF_CTRL || paddr == `DPRB_OFF_WIDTH ||
            paddr == `DPRB_OFF_COUNT);
        ctrl_next = ctrl_reg;
        width_next = width_reg;
        prdata_next = prdata_reg;
        pready_next = apbSetup;
        pslverr_next = apbSetup & unmapped;
        if (apbSetup) begin
            case (paddr)
                `DPRB_OFF_CTRL: prdata_next = 32'(ctrl_reg);
                `DPRB_OFF_WIDTH: prdata_next = 32'(width_reg);
                `DPRB_OFF_COUNT: prdata_next = {rdCount_reg, wrCount_reg};
                default: prdata_next = '0;
            endcase
        end
        // Writes land only on the completing access edge
        if (apbWrite && paddr == `DPRB_OFF_CTRL) ctrl_next = pwdata[`DPRB_CTRL_BITS-1:0];
        if (apbWrite && paddr == `DPRB_OFF_WIDTH) width_next = pwdata[`DPRB_WIDTH_REG_BITS-1:0];
        if (!rst_n) begin
            ctrl_next = `DPRB_CTRL_RESET;
            width_next = `DPRB_WIDTH_RESET;
            prdata_next = '0;
            pready_next = 1'b0;
            pslverr_next = 1'b0;
        end
    end

    // State registers
    always_ff @(posedge mclk) begin
        ctrl_reg <= ctrl_next;
        width_reg <= width_next;
        prdata_reg <= prdata_next;
        pready_reg <= pready_next;
        pslverr_reg <= pslverr_next;
        wrCount_reg <= wrCount_next;
        rdCount_reg <= rdCount_next;
        outA_reg <= outA_next;
        outB_reg <= outB_next;
        pipeA_reg <= pipeA_next;
        pipeB_reg <= pipeB_next;
    end

    // Outputs straight from flops
    assign prdata = prdata_reg;
    assign pready = pready_reg;
    assign pslverr = pslverr_reg;
    assign readWordOut = outB_reg;
    assign firstPortReadWord = outA_reg[`DPRB_PORT_WIDTH-1:0]; // R14
    assign secondPortReadWord = outB_reg[`DPRB_PORT_WIDTH-1:0]; // R14

    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rst_n);

    chk_write_count: assert property ( // R15
        (|wrLaneA) && !(|wrLaneB) |=> wrCount_reg == $past(wrCount_reg) + 16'h0001)
        else $error("write count did not follow a selected write");
    chk_lane_write: assert property ( // R4
        wrLaneA[0] && !(|wrLaneB) |=> mem[$past(baseA)] == $past(wordA[LB-1:0]))
        else $error("enabled lane not written");
    chk_read_direct: assert property ( // R5
        !pipeOn && rdEvB ##1 !$changed(pipeOn) |-> outB_reg == $past(rdB))
        else $error("direct read data wrong");
    chk_read_hold: assert property ( // R15
        !pipeOn && !rdEvB && !$changed(ctrl_reg) |=> $stable(outB_reg))
        else $error("read output moved without a selected read");
    chk_pipe_stage: assert property ( // R6
        pipeOn && rdEvB ##1 !portB.stb [*8] ##2 portB.stb && pipeOn |=> outB_reg == $past(rdB, 11))
        else $error("pipelined read data wrong");
    chk_width_clip: assert property ( // R2
        !pipeOn && rdEvB |=> (outB_reg & ~$past(bitMaskB)) == '0)
        else $error("read bits beyond width not zero");
    chk_lane_bound: assert property ( // R9
        (mode == DPRB_MODE_SINGLE) |-> baseB < `DPRB_LOC_BITS'(`DPRB_LANE_TOTAL / 2))
        else $error("single block mapped outside its half");
    chk_cascade_depth: assert property ( // R8
        mode == DPRB_MODE_CASCADE && ctrl_reg[`DPRB_CTRL_DEPTH_B] == DPRB_DEPTH_1024 |->
        baseB == {portB.loc[`DPRB_LOC_BITS-2:0], 1'b0})
        else $error("1024-deep cascade mapping wrong");
    chk_dual_read: assert property ( // R11
        trueDual && !pipeOn && rdEvA ##1 !$changed(pipeOn) |-> outA_reg == $past(rdA))
        else $error("first port read data wrong");
    chk_port_width: assert property ( // R14
        trueDual && !pipeOn && rdEvA |=> outA_reg[`DPRB_MAX_WIDTH-1:`DPRB_PORT_WIDTH] == '0)
        else $error("true dual-port word wider than port");
endmodule : dprb_ram_top

//--- dprb_fabric_model.sv
// Fabric-side user logic that drives the RAM block port pins
`timescale 1ns/1ps
module dprb_fabric_model (
    // Clock
    input wire logic mclk,
    // Port clocks: write, read, first, second
    output logic [3:0] pinClk,
    // Simple write side
    output logic [10:0] wLoc,
    output logic [35:0] wWord,
    output logic [3:0] wLane,
    output logic wSel,
    // Simple read side
    output logic [10:0] rLoc,
    output logic rSel,
    // True dual-port sides
    output logic [1:0][10:0] tLoc,
    output logic [1:0][17:0] tWord,
    output logic [1:0] tStb,
    output logic [1:0] tSel
);
    // Pins idle at time zero; port clocks rest low between accesses
    initial begin
        {pinClk, wLoc, wWord, wLane, wSel, rLoc, rSel, tLoc, tWord, tStb, tSel} = '0;
    end

    // One port clock; pins are steady 3 mclk before and after each edge
    task automatic pulse(input int p);
        repeat (3) @(posedge mclk);
        pinClk[p] <= 1'b1;
        repeat (3) @(posedge mclk);
        pinClk[p] <= 1'b0;
        repeat (3) @(posedge mclk);
    endtask : pulse

    // Accesses run one at a time, so no location is ever hit twice at once
    task automatic wr(input logic [10:0] loc, input logic [35:0] word, input logic [3:0] ln,
            input logic sel);
        wLoc <= loc;
        wWord <= word;
        wLane <= ln;
        wSel <= sel;
        pulse(0);
        wSel <= 1'b0;
        wWord <= ~word; // Stale data must never look valid
        @(posedge mclk);
    endtask : wr

    // Simple read port access
    task automatic rd(input logic [10:0] loc, input logic sel);
        rLoc <= loc;
        rSel <= sel;
        pulse(1);
        rSel <= 1'b0;
        @(posedge mclk);
    endtask : rd

    // True dual-port access on port p
    task automatic tp(input int p, input logic stb, input logic [10:0] loc,
            input logic [17:0] word);
        tLoc[p] <= loc;
        tWord[p] <= word;
        tStb[p] <= stb;
        tSel[p] <= 1'b1;
        pulse(p + 2);
        tSel[p] <= 1'b0;
        tWord[p] <= ~word;
        @(posedge mclk);
    endtask : tp
endmodule : dprb_fabric_model

//--- dprb_ram_top_tb.sv
// Self-checking bench for the dual-port RAM block
`timescale 1ns/1ps
module dprb_ram_top_tb;
    logic mclk = 1'b0;
    logic rst_n = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rdat;
    logic pready, pslverr, err;
    logic [3:0] pinClk, wLane;
    logic [10:0] wLoc, rLoc;
    logic [35:0] wWord, readWordOut;
    logic wSel, rSel;
    logic [1:0][10:0] tLoc;
    logic [1:0][17:0] tWord;
    logic [1:0] tStb, tSel;
    logic [17:0] firstPortReadWord, secondPortReadWord;
    int n_mismatch = 0;
    int num_checks = 0;
    int cyc = 0;

    // 40 MHz clock
    always #12.5 mclk = ~mclk;

    dprb_fabric_model dprb_fabric_model_i (.mclk(mclk), .pinClk(pinClk), .wLoc(wLoc),
        .wWord(wWord), .wLane(wLane), .wSel(wSel), .rLoc(rLoc), .rSel(rSel), .tLoc(tLoc),
        .tWord(tWord), .tStb(tStb), .tSel(tSel));

    dprb_ram_top dprb_ram_top_i (.mclk(mclk), .rst_n(rst_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .writeClock(pinClk[0]), .writeLocation(wLoc), .writeWordIn(wWord),
        .writeLaneEn(wLane), .writePortSelect(wSel), .readClock(pinClk[1]),
        .readLocation(rLoc), .readPortSelect(rSel), .readWordOut(readWordOut),
        .firstPortClock(pinClk[2]), .firstPortLocation(tLoc[0]),
        .firstPortWriteWord(tWord[0]), .firstPortWriteStrobe(tStb[0]),
        .firstPortSelect(tSel[0]), .firstPortReadWord(firstPortReadWord),
        .secondPortClock(pinClk[3]), .secondPortLocation(tLoc[1]),
        .secondPortWriteWord(tWord[1]), .secondPortWriteStrobe(tStb[1]),
        .secondPortSelect(tSel[1]), .secondPortReadWord(secondPortReadWord));

    // Compare and count
    task automatic chk(input string name, input logic [35:0] seen, input logic [35:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk

    task automatic final_report();
        if (n_mismatch == 0 && num_checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : final_report

    // APB transfer; waits for pready, then takes data and releases
    task automatic apb(input logic wr, input logic [11:0] addr, input logic [31:0] data);
        @(posedge mclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= addr;
        pwdata <= data;
        @(posedge mclk);
        penable <= 1'b1;
        do @(posedge mclk); while (pready !== 1'b1);
        rdat = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic rchk(input string name, input logic [11:0] addr, input logic [31:0] exp);
        apb(1'b0, addr, 32'h0);
        chk(name, {4'h0, rdat}, {4'h0, exp});
    endtask : rchk

    // Hang guard: the whole run needs well under 2000 cycles
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 5000) begin
            n_mismatch++;
            final_report();
        end
    end

    // Main sequence
    initial begin
        repeat (12) @(posedge mclk);
        rst_n <= 1'b1;
        rchk("ctrl", 12'h000, 32'h0);
        rchk("width", 12'h004, 32'h1212);
        rchk("unmapped", 12'h00c, 32'h0);
        chk("slverr", err, 36'h1);
        dprb_fabric_model_i.wr(11'h005, 36'h2abcd, 4'h3, 1'b1);
        dprb_fabric_model_i.rd(11'h005, 1'b1);
        chk("single", readWordOut, 36'h2abcd);
        dprb_fabric_model_i.wr(11'h005, 36'h3ffff, 4'h1, 1'b1);
        dprb_fabric_model_i.rd(11'h005, 1'b1);
        chk("lane0", readWordOut, 36'h2abff);
        dprb_fabric_model_i.wr(11'h005, 36'h0, 4'h3, 1'b0);
        dprb_fabric_model_i.wr(11'h006, 36'h123, 4'h3, 1'b1);
        dprb_fabric_model_i.rd(11'h005, 1'b1);
        chk("nosel wr", readWordOut, 36'h2abff);
        dprb_fabric_model_i.rd(11'h006, 1'b0);
        chk("nosel rd", readWordOut, 36'h2abff);
        dprb_fabric_model_i.rd(11'h006, 1'b1);
        chk("loc6", readWordOut, 36'h123);
        apb(1'b1, 12'h000, 32'h4);
        dprb_fabric_model_i.rd(11'h005, 1'b1);
        dprb_fabric_model_i.rd(11'h006, 1'b0);
        chk("pipe", readWordOut, 36'h2abff);
        rchk("count", 12'h008, 32'h00050003);
        apb(1'b1, 12'h000, 32'h1);
        apb(1'b1, 12'h004, 32'h2424);
        dprb_fabric_model_i.wr(11'h009, 36'h987654321, 4'hf, 1'b1);
        dprb_fabric_model_i.rd(11'h009, 1'b1);
        chk("512x36", readWordOut, 36'h987654321);
        apb(1'b1, 12'h000, 32'h141);
        apb(1'b1, 12'h004, 32'h0909);
        dprb_fabric_model_i.wr(11'h7ff, 36'h1a5, 4'h1, 1'b1);
        dprb_fabric_model_i.rd(11'h7ff, 1'b1);
        chk("2048x9", readWordOut, 36'h1a5);
        dprb_fabric_model_i.rd(11'h00b, 1'b1);
        chk("remap", readWordOut, 36'h155);
        apb(1'b1, 12'h004, 32'h1212);
        apb(1'b1, 12'h000, 32'h0a1);
        dprb_fabric_model_i.wr(11'h3ff, 36'h0abcd, 4'h3, 1'b1);
        dprb_fabric_model_i.rd(11'h3ff, 1'b1);
        chk("1024x18", readWordOut, 36'h0abcd);
        apb(1'b1, 12'h000, 32'h0a2);
        dprb_fabric_model_i.tp(0, 1'b1, 11'h3ff, 18'h15a5a);
        dprb_fabric_model_i.tp(1, 1'b0, 11'h3ff, 18'h0);
        chk("second_port_read_word", {18'h0, secondPortReadWord}, 36'h15a5a);
        apb(1'b1, 12'h000, 32'h0ba);
        dprb_fabric_model_i.tp(1, 1'b1, 11'h010, 18'h0f0f0);
        dprb_fabric_model_i.tp(0, 1'b0, 11'h010, 18'h0);
        chk("port1 inv", {18'h0, firstPortReadWord}, 36'h0f0f0);
        dprb_fabric_model_i.tp(0, 1'b0, 11'h3ff, 18'h0);
        chk("shared rd", {18'h0, firstPortReadWord}, 36'h15a5a);
        final_report();
    end
endmodule : dprb_ram_top_tb
